/* File: hw/eaw_core.sv */
// Exception arbiter and wait control: latches and arbitrates requests,
// drives the vector code, break entry, flag protection and clock gating.
// Assumes the core reports instruction boundaries and vector fetches.
//
// How it works
// [RULE_01] Core stacks registers, sets mask on entry
// [RULE_02] Latch requests, arbitrate, present vector code
// [RULE_03] Latched request holds until serviced or unmasked
// [RULE_04] Hardware interrupt waits for instruction completion
// [RULE_05] Take request only unmasked and enabled
// [RULE_06] Highest pending priority is serviced first
// [RULE_07] Software trap ignores the mask bit
// [RULE_08] Trap stacks PC, hardware stacks PC minus one
// [RULE_09] Fixed priority order, reset then trap first
// [RULE_10] Each source sets its own pending flag
// [RULE_11] Low register holds flags six to one
// [RULE_12] Mid register holds flags fourteen to seven
// [RULE_13] High register holds flags twenty to fifteen
// [RULE_14] Resets share top priority, never arbitrated
// [RULE_15] Break request forces the trap vector fetch
// [RULE_16] Break protects flags unless clear enable set
// [RULE_17] Two-step clears stay protected during break
// [RULE_18] Wait or stop clears mask, stops core
// [RULE_19] Wait gates core clocks, peripherals keep running
// [RULE_20] Enabled request wakes core, stacking next cycle
// [RULE_21] Reset or emulation break ends wait
// [RULE_22] Pending registers read-only, mirror request lines
//
// The register addresses and the APB interface to the registers are this design's own decisions.
module eaw_core (
  // Clock and reset
  input  wire logic                          mclk_in,
  input  wire logic                          reset_in,
  // APB
  input  wire logic                          psel_in,
  input  wire logic                          penable_in,
  input  wire logic                          pwrite_in,
  input  wire logic [7:0]                    paddr_in,
  input  wire logic [31:0]                   pwdata_in,
  output logic [31:0]                        prdata_out,
  output logic                               pready_out,
  output logic                               pslverr_out,
  // Peripheral requests and their enables
  input  wire logic [eaw_pkg::NUM_SRC-1:0]   irq_req_in,
  input  wire logic [eaw_pkg::NUM_SRC-1:0]   irq_enable_in,
  // Core side
  input  wire eaw_pkg::eaw_core_evt_t        core_evt_in,
  input  wire logic                          ccr_mask_in,
  input  wire logic                          break_req_in,
  input  wire logic                          emulation_in,
  input  wire logic                          watchdog_disable_cfg_in,
  output logic                               int_start_out,
  output logic [eaw_pkg::VEC_W-1:0]          vector_sel_out,
  output logic                               stack_pc_minus1_out,
  output logic                               set_mask_out,
  output logic                               clear_mask_out,
  // Clocking and break status
  output logic                               core_clk_en_out,
  output logic                               periph_clk_en_out,
  output logic                               watchdog_run_out,
  output logic                               break_state_out,
  output logic                               flag_clear_allow_out
);

  eaw_pkg::eaw_state_t               state;
  logic [eaw_pkg::NUM_SRC-1:0]       pend;
  logic                              pend_any;
  logic [eaw_pkg::IDX_W-1:0]         pend_idx;
  logic [eaw_pkg::VEC_W-1:0]         hw_vec;
  logic [eaw_pkg::FLAG_W-1:0]        flags;
  logic                              break_wake_flag;
  logic                              break_flag_clear_enable;
  logic                              mask_q;
  logic                              mask_fell;
  logic                              take_hw;
  logic                              brk_wait_wake;
  logic                              bus_hit;
  logic                              wr_en;
  logic [31:0]                       rdata;

  // Gate with enables before arbitration
  // [RULE_05] mask and enable
  assign pend = irq_req_in & irq_enable_in;

  // [RULE_06] highest wins first
  eaw_prio_enc u_prio (
    .req_in  (pend),
    .any_out (pend_any),
    .idx_out (pend_idx)
  );

  // [RULE_09] index maps to vector order
  assign hw_vec  = eaw_pkg::VEC_HW_BASE + {1'b0, pend_idx};
  assign take_hw = pend_any & ~ccr_mask_in;

  // Break ends wait only in emulation
  // [RULE_21] emulation break wake
  assign brk_wait_wake = break_req_in & emulation_in;

  // Mask clear releases a latched request
  assign mask_fell = mask_q & ~ccr_mask_in;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      mask_q <= 1'b0;
    end else begin
      mask_q <= ccr_mask_in;
    end
  end

  // Main sequencer: latch, vector, wait and stop
  // Reset needs no arbitration; it simply restarts at the reset code.
  // [RULE_14] reset outranks all
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state               <= eaw_pkg::ST_RUN;
      vector_sel_out      <= eaw_pkg::VEC_RESET;
      stack_pc_minus1_out <= 1'b0;
      int_start_out       <= 1'b0;
      set_mask_out        <= 1'b0;
      clear_mask_out      <= 1'b0;
      core_clk_en_out     <= 1'b1;
      periph_clk_en_out   <= 1'b1;
    end else begin
      int_start_out  <= 1'b0;
      set_mask_out   <= 1'b0;
      clear_mask_out <= 1'b0;
      unique case (state)
        eaw_pkg::ST_RUN: begin
          // [RULE_04] only at boundary
          if (core_evt_in.instr_done) begin
            if (break_req_in) begin
              // [RULE_15] break uses trap vector
              state               <= eaw_pkg::ST_SERVICE;
              vector_sel_out      <= eaw_pkg::VEC_TRAP;
              stack_pc_minus1_out <= 1'b0;
              int_start_out       <= 1'b1;
              set_mask_out        <= 1'b1;
            end else if (core_evt_in.trap_exec) begin
              // [RULE_07] trap ignores mask
              // [RULE_08] trap stacks PC
              state               <= eaw_pkg::ST_SERVICE;
              vector_sel_out      <= eaw_pkg::VEC_TRAP;
              stack_pc_minus1_out <= 1'b0;
              int_start_out       <= 1'b1;
              set_mask_out        <= 1'b1;
            end else if (take_hw) begin
              // [RULE_02] latch and present
              // [RULE_01] core sets mask
              // [RULE_08] hardware stacks PC minus one
              state               <= eaw_pkg::ST_SERVICE;
              vector_sel_out      <= hw_vec;
              stack_pc_minus1_out <= 1'b1;
              int_start_out       <= 1'b1;
              set_mask_out        <= 1'b1;
            end else if (core_evt_in.wait_exec) begin
              // [RULE_18] wait clears mask
              // [RULE_19] core clock off only
              state           <= eaw_pkg::ST_WAIT;
              clear_mask_out  <= 1'b1;
              core_clk_en_out <= 1'b0;
            end else if (core_evt_in.stop_exec) begin
              // [RULE_18] stop clears mask
              state             <= eaw_pkg::ST_STOP;
              clear_mask_out    <= 1'b1;
              core_clk_en_out   <= 1'b0;
              periph_clk_en_out <= 1'b0;
            end
          end
        end
        eaw_pkg::ST_SERVICE: begin
          // [RULE_03] hold until serviced or unmasked
          if (core_evt_in.vec_fetch || mask_fell) begin
            state <= eaw_pkg::ST_RUN;
          end
        end
        eaw_pkg::ST_WAIT: begin
          if (brk_wait_wake) begin
            state               <= eaw_pkg::ST_SERVICE;
            vector_sel_out      <= eaw_pkg::VEC_TRAP;
            stack_pc_minus1_out <= 1'b0;
            int_start_out       <= 1'b1;
            set_mask_out        <= 1'b1;
            core_clk_en_out     <= 1'b1;
          end else if (take_hw) begin
            // [RULE_20] stacking one cycle later
            state               <= eaw_pkg::ST_SERVICE;
            vector_sel_out      <= hw_vec;
            stack_pc_minus1_out <= 1'b1;
            int_start_out       <= 1'b1;
            set_mask_out        <= 1'b1;
            core_clk_en_out     <= 1'b1;
          end
        end
        eaw_pkg::ST_STOP: begin
          // Recovery delay is left to the clock generator
          if (brk_wait_wake || take_hw) begin
            state               <= eaw_pkg::ST_SERVICE;
            vector_sel_out      <= brk_wait_wake ? eaw_pkg::VEC_TRAP : hw_vec;
            stack_pc_minus1_out <= ~brk_wait_wake;
            int_start_out       <= 1'b1;
            set_mask_out        <= 1'b1;
            core_clk_en_out     <= 1'b1;
            periph_clk_en_out   <= 1'b1;
          end
        end
      endcase
    end
  end

  // Break state lasts from break entry to the handler's return
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      break_state_out <= 1'b0;
    end else if ((state == eaw_pkg::ST_RUN && core_evt_in.instr_done && break_req_in)
                 || (state != eaw_pkg::ST_RUN && state != eaw_pkg::ST_SERVICE
                     && brk_wait_wake)) begin
      break_state_out <= 1'b1;
    end else if (core_evt_in.return_exec) begin
      break_state_out <= 1'b0;
    end
  end

  // Flag protection for other modules; they gate both clearing steps
  // with it, so a step begun before break still cannot finish inside.
  // [RULE_16] protect unless enabled
  // [RULE_17] two-step held off
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      flag_clear_allow_out <= 1'b1;
    end else begin
      flag_clear_allow_out <= ~break_state_out | break_flag_clear_enable;
    end
  end

  // Watchdog runs in wait when not disabled
  // [RULE_21] watchdog stays in wait
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      watchdog_run_out <= 1'b0;
    end else begin
      watchdog_run_out <= ~watchdog_disable_cfg_in & (state != eaw_pkg::ST_STOP);
    end
  end

  // Break-wake flag: set wins over a software clear
  // [RULE_21] break in wait flags
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      break_wake_flag <= eaw_pkg::RST_BREAK_WAKE;
    end else if (state == eaw_pkg::ST_WAIT && brk_wait_wake) begin
      break_wake_flag <= 1'b1;
    end else if (wr_en && paddr_in == eaw_pkg::OFS_BRK_STATUS
                 && !pwdata_in[eaw_pkg::BREAK_WAKE_BIT]) begin
      break_wake_flag <= 1'b0;
    end
  end

  // Break flag control register
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      break_flag_clear_enable <= eaw_pkg::RST_CLR_EN;
    end else if (wr_en && paddr_in == eaw_pkg::OFS_BRK_CTRL) begin
      break_flag_clear_enable <= pwdata_in[eaw_pkg::CLR_EN_BIT];
    end
  end

  // Flags mirror raw request lines; flags 17 to 20 have no source
  // [RULE_10] one flag per source
  assign flags = {4'h0, irq_req_in};

  // Read mux; pending registers ignore writes
  // [RULE_22] read-only mirrors
  always_comb begin
    rdata   = 32'h0000_0000;
    bus_hit = 1'b1;
    unique case (paddr_in)
      eaw_pkg::OFS_PEND_LOW: begin
        // [RULE_11] six flags, low two zero
        rdata[7:eaw_pkg::LOW_FLAG_LSB] = flags[5:0];
      end
      eaw_pkg::OFS_PEND_MID: begin
        // [RULE_12] flags fourteen to seven
        rdata[7:0] = flags[13:6];
      end
      eaw_pkg::OFS_PEND_HIGH: begin
        // [RULE_13] top two zero
        rdata[5:0] = flags[19:14];
      end
      eaw_pkg::OFS_BRK_STATUS: rdata[eaw_pkg::BREAK_WAKE_BIT] = break_wake_flag;
      eaw_pkg::OFS_BRK_CTRL:   rdata[eaw_pkg::CLR_EN_BIT] = break_flag_clear_enable;
      default:                 bus_hit = 1'b0;
    endcase
  end

  eaw_apb_slave u_apb (
    .mclk_in     (mclk_in),
    .reset_in    (reset_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .rdata_in    (rdata),
    .hit_in      (bus_hit),
    .wr_en_out   (wr_en),
    .prdata_out  (prdata_out),
    .pready_out  (pready_out),
    .pslverr_out (pslverr_out)
  );

  // Checks on the sequencer
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  AST_VEC_HELD: assert property ( // [RULE_03]
    (state == eaw_pkg::ST_SERVICE && $past(state) == eaw_pkg::ST_SERVICE)
      |-> $stable(vector_sel_out))
    else $error("vector code changed while latched");

  AST_BOUNDARY: assert property ( // [RULE_04]
    (int_start_out && $past(state) == eaw_pkg::ST_RUN) |-> $past(core_evt_in.instr_done))
    else $error("interrupt started mid instruction");

  AST_MASKED: assert property ( // [RULE_05]
    (state == eaw_pkg::ST_RUN && core_evt_in.instr_done && ccr_mask_in
     && !core_evt_in.trap_exec && !break_req_in) |=> !int_start_out)
    else $error("masked request was taken");

  AST_TRAP: assert property ( // [RULE_07]
    (state == eaw_pkg::ST_RUN && core_evt_in.instr_done && core_evt_in.trap_exec)
      |=> int_start_out && vector_sel_out == eaw_pkg::VEC_TRAP)
    else $error("software trap not taken");

  AST_PC_ADJ: assert property ( // [RULE_08]
    int_start_out |-> stack_pc_minus1_out == (vector_sel_out >= eaw_pkg::VEC_HW_BASE))
    else $error("wrong stacked PC adjust");

  AST_TOP_PRIO: assert property ( // [RULE_06]
    (state == eaw_pkg::ST_RUN && core_evt_in.instr_done && !core_evt_in.trap_exec
     && !break_req_in && !ccr_mask_in && pend[0]) |=> vector_sel_out == eaw_pkg::VEC_HW_BASE)
    else $error("top priority source not chosen");

  AST_WAIT_CLK: assert property ( // [RULE_19]
    state == eaw_pkg::ST_WAIT |-> !core_clk_en_out && periph_clk_en_out)
    else $error("wrong clocks in wait");

  AST_WAKE: assert property ( // [RULE_20]
    (state == eaw_pkg::ST_WAIT && take_hw) |=> int_start_out && core_clk_en_out)
    else $error("wait wake not one cycle");

  AST_BRK_WAKE: assert property ( // [RULE_21]
    (state == eaw_pkg::ST_WAIT && brk_wait_wake) |=> break_wake_flag ##0 break_state_out)
    else $error("break wake not flagged");

  AST_PROTECT: assert property ( // [RULE_16]
    (break_state_out && !break_flag_clear_enable) |=> !flag_clear_allow_out)
    else $error("flags not protected in break");

  AST_WAIT_MASK: assert property ( // [RULE_18]
    ((state == eaw_pkg::ST_WAIT || state == eaw_pkg::ST_STOP)
     && $past(state) == eaw_pkg::ST_RUN) |-> clear_mask_out)
    else $error("wait or stop entry did not clear mask");

  COV_WAKE: cover property (state == eaw_pkg::ST_WAIT ##1 int_start_out);
  COV_BREAK: cover property (break_state_out && break_wake_flag);
  COV_TWO: cover property (state == eaw_pkg::ST_RUN && take_hw && $countones(pend) > 1);
  COV_TRAP: cover property (int_start_out && vector_sel_out == eaw_pkg::VEC_TRAP);

endmodule

/* File: hw/eaw_pkg.sv */
// Shared constants and types for the exception arbiter and wait control.
// Assumes one 100 MHz bus clock and a synchronous, active-high reset.
package eaw_pkg;

  // Source counts and flag layout
  localparam int unsigned NUM_SRC  = 16;
  localparam int unsigned IDX_W    = 4;
  localparam int unsigned FLAG_W   = 20;
  localparam int unsigned VEC_W    = 5;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_PEND_LOW   = 8'h00;
  localparam logic [7:0] OFS_PEND_MID   = 8'h04;
  localparam logic [7:0] OFS_PEND_HIGH  = 8'h08;
  localparam logic [7:0] OFS_BRK_STATUS = 8'h0C;
  localparam logic [7:0] OFS_BRK_CTRL   = 8'h10;

  // Field positions
  localparam int unsigned BREAK_WAKE_BIT = 1;
  localparam int unsigned CLR_EN_BIT     = 0;
  localparam int unsigned LOW_FLAG_LSB   = 2;

  // Reset values
  localparam logic RST_BREAK_WAKE = 1'b0;
  localparam logic RST_CLR_EN     = 1'b0;

  // Vector selection codes, reset first
  localparam logic [4:0] VEC_RESET   = 5'h00;
  localparam logic [4:0] VEC_TRAP    = 5'h01;
  localparam logic [4:0] VEC_HW_BASE = 5'h02;

  // Core handshake events, each a one-cycle pulse
  typedef struct packed {
    logic instr_done;
    logic trap_exec;
    logic wait_exec;
    logic stop_exec;
    logic return_exec;
    logic vec_fetch;
  } eaw_core_evt_t;

  // Controller states
  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_SERVICE = 2'b01,
    ST_WAIT    = 2'b10,
    ST_STOP    = 2'b11
  } eaw_state_t;

endpackage

/* File: hw/eaw_prio_enc.sv */
// Fixed-priority encoder: lowest index wins.
// Assumes requests are already gated by their enables.
module eaw_prio_enc (
  // Requests
  input  wire logic [eaw_pkg::NUM_SRC-1:0] req_in,
  // Result
  output logic                             any_out,
  output logic [eaw_pkg::IDX_W-1:0]        idx_out
);

  logic [eaw_pkg::NUM_SRC:0]   above;
  logic [eaw_pkg::NUM_SRC-1:0] hit;

  assign above[0] = 1'b0;

  // One-hot winner, chained from the top priority
  for (genvar i = 0; i < eaw_pkg::NUM_SRC; i++) begin : g_chain
    assign hit[i]     = req_in[i] & ~above[i];
    assign above[i+1] = above[i] | req_in[i];
  end

  assign any_out = above[eaw_pkg::NUM_SRC];

  // Encode the single hot bit
  always_comb begin
    idx_out = '0;
    for (int i = 0; i < eaw_pkg::NUM_SRC; i++) begin
      if (hit[i]) begin
        idx_out = i[eaw_pkg::IDX_W-1:0];
      end
    end
  end

endmodule

/* File: hw/eaw_apb_slave.sv */
// APB slave handshake with one wait state and registered answer.
// Assumes the owner supplies read data and an address-hit flag.
module eaw_apb_slave (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  // APB request
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  // Owner side
  input  wire logic [31:0] rdata_in,
  input  wire logic        hit_in,
  output logic             wr_en_out,
  // APB answer
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out
);

  // Write lands at the completing edge only
  assign wr_en_out = psel_in & penable_in & pready_out & pwrite_in & hit_in;

  // Answer one cycle into the access phase; data captured then
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (psel_in && penable_in && !pready_out) begin
      pready_out  <= 1'b1;
      prdata_out  <= (hit_in && !pwrite_in) ? rdata_in : 32'h0000_0000;
      pslverr_out <= ~hit_in;
    end else begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

endmodule

/* File: testbench/eaw_core_model.sv */
// Core-side partner: raises the mask on entry and fetches the vector.
// Assumes the bench drives all other core events itself.
module eaw_core_model (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic reset_in,
  // From the arbiter and bench
  input  wire logic int_start_in,
  input  wire logic set_mask_in,
  input  wire logic clear_mask_in,
  input  wire logic ret_in,
  input  wire logic slow_in,
  // To the arbiter
  output logic      vec_fetch_out,
  output logic      mask_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] cnt;

  // Mask on entry, clear on wait, stop or return
  always_ff @(posedge mclk_in) begin
    if (reset_in) mask_out <= 1'b1;
    else if (set_mask_in) mask_out <= 1'b1;
    else if (clear_mask_in || ret_in) mask_out <= 1'b0;
  end

  // Fetch follows stacking; slow mode stretches it
  always_ff @(posedge mclk_in) begin
    vec_fetch_out <= 1'b0;
    if (reset_in) cnt <= 3'h0;
    else if (int_start_in) cnt <= slow_in ? 3'h5 : 3'h1;
    else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
      vec_fetch_out <= (cnt == 3'h1);
    end
  end
endmodule

/* File: testbench/tb_exception_arbiter_wait_control.sv */
// Self-checking bench for the exception arbiter and wait control.
// Assumes the core model answers vector fetches; APB master here.
module tb_exception_arbiter_wait_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_in, reset_in, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] irq_req, irq_en;
  logic [5:0]  evt_drv;
  logic        brk, slow, mask, fetch, int_start, pcm1, set_m, clr_m, err;
  logic        core_clk, per_clk, wdog, brk_st, fc_allow, emul, wdog_dis;
  logic [4:0]  vec;
  eaw_pkg::eaw_core_evt_t core_evt;
  int          errors, tests_run, cycles;

  // Bench drives events; the model owns the fetch
  always_comb begin
    core_evt = evt_drv;
    core_evt.vec_fetch = fetch;
  end

  eaw_core u_dut (.mclk_in(mclk_in), .reset_in(reset_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .irq_req_in(irq_req), .irq_enable_in(irq_en), .core_evt_in(core_evt),
    .ccr_mask_in(mask), .break_req_in(brk), .emulation_in(emul),
    .watchdog_disable_cfg_in(wdog_dis), .int_start_out(int_start), .vector_sel_out(vec),
    .stack_pc_minus1_out(pcm1), .set_mask_out(set_m), .clear_mask_out(clr_m),
    .core_clk_en_out(core_clk), .periph_clk_en_out(per_clk), .watchdog_run_out(wdog),
    .break_state_out(brk_st), .flag_clear_allow_out(fc_allow));

  eaw_core_model u_core (.mclk_in(mclk_in), .reset_in(reset_in), .int_start_in(int_start),
    .set_mask_in(set_m), .clear_mask_in(clr_m), .ret_in(evt_drv[1]), .slow_in(slow),
    .vec_fetch_out(fetch), .mask_out(mask));

  // Clock and hang guard
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; waits on pready, no assumed latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    do @(posedge mclk_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Event for one cycle; registered answer visible after next edge
  task automatic pulse(input logic [5:0] e);
    @(posedge mclk_in);
    evt_drv <= e;
    @(posedge mclk_in);
    evt_drv <= 6'h00;
    #1;
  endtask

  task automatic wait_fetch();
    do @(posedge mclk_in); while (fetch !== 1'b1);
    pulse(6'h02);
  endtask

  task automatic test_regs();
    irq_req <= 16'hA5C3;
    apb(1'b0, eaw_pkg::OFS_PEND_LOW, 32'h0);
    chk("pend_low", {24'h0, irq_req[5:0], 2'b00}, rd);
    apb(1'b1, eaw_pkg::OFS_PEND_MID, 32'hFF);
    apb(1'b0, eaw_pkg::OFS_PEND_MID, 32'h0);
    chk("pend_mid", {24'h0, irq_req[13:6]}, rd);
    apb(1'b0, eaw_pkg::OFS_PEND_HIGH, 32'h0);
    chk("pend_high", {30'h0, irq_req[15:14]}, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    apb(1'b0, eaw_pkg::OFS_BRK_CTRL, 32'h0);
    chk("clr_en_reset", 32'h0, rd);
    irq_req <= 16'h0000;
    $display("test_regs done");
  endtask

  task automatic test_mask_trap();
    irq_req <= 16'h0004;
    pulse(6'h20);
    chk("masked_start", 32'h0, {31'h0, int_start});
    pulse(6'h30);
    chk("trap_start", 32'h1, {31'h0, int_start});
    chk("trap_vec", 32'h1, {27'h0, vec});
    chk("trap_pcm1", 32'h0, {31'h0, pcm1});
    wait_fetch();
    irq_en <= 16'h0000;
    pulse(6'h20);
    chk("disabled_start", 32'h0, {31'h0, int_start});
    irq_req <= 16'h0000;
    $display("test_mask_trap done");
  endtask

  task automatic test_priority();
    irq_en <= 16'hFFFF;
    slow <= 1'b1;
    irq_req <= 16'h0088;
    pulse(6'h20);
    chk("prio_vec", 32'h5, {27'h0, vec});
    chk("prio_pcm1", 32'h1, {31'h0, pcm1});
    irq_req <= 16'h0089;
    pulse(6'h20);
    chk("latched_start", 32'h0, {31'h0, int_start});
    chk("latched_vec", 32'h5, {27'h0, vec});
    wait_fetch();
    pulse(6'h20);
    chk("prio_top_vec", 32'h2, {27'h0, vec});
    wait_fetch();
    slow <= 1'b0;
    irq_req <= 16'h0000;
    $display("test_priority done");
  endtask

  task automatic test_wait();
    pulse(6'h28);
    chk("wait_clr_mask", 32'h1, {31'h0, clr_m});
    chk("wait_core_clk", 32'h0, {31'h0, core_clk});
    chk("wait_periph_clk", 32'h1, {31'h0, per_clk});
    @(posedge mclk_in);
    irq_req <= 16'h0020;
    do @(posedge mclk_in); while (int_start !== 1'b1 && cycles < 2900);
    #1;
    chk("wake_vec", 32'h7, {27'h0, vec});
    chk("wake_core_clk", 32'h1, {31'h0, core_clk});
    chk("wait_watchdog", 32'h1, {31'h0, wdog});
    irq_req <= 16'h0000;
    wait_fetch();
    // Stop, then wake on the top source
    pulse(6'h24);
    chk("stop_clr_mask", 32'h1, {31'h0, clr_m});
    chk("stop_periph_clk", 32'h0, {31'h0, per_clk});
    @(posedge mclk_in);
    irq_req <= 16'h0001;
    @(posedge mclk_in);
    #1;
    chk("stop_watchdog", 32'h0, {31'h0, wdog});
    chk("stop_wake_vec", 32'h2, {27'h0, vec});
    chk("stop_wake_clk", 32'h1, {31'h0, per_clk & core_clk});
    irq_req <= 16'h0000;
    wait_fetch();
    // Disabled watchdog stops running
    @(posedge mclk_in);
    wdog_dis <= 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    chk("watchdog_off", 32'h0, {31'h0, wdog});
    wdog_dis <= 1'b0;
    $display("test_wait done");
  endtask

  task automatic test_break();
    brk <= 1'b1;
    pulse(6'h20);
    chk("break_vec", 32'h1, {27'h0, vec});
    brk <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1;
    chk("break_state", 32'h1, {31'h0, brk_st});
    chk("break_protect", 32'h0, {31'h0, fc_allow});
    apb(1'b1, eaw_pkg::OFS_BRK_CTRL, 32'h1);
    repeat (2) @(posedge mclk_in);
    #1;
    chk("break_allow", 32'h1, {31'h0, fc_allow});
    // Handler return ends the break state
    pulse(6'h02);
    chk("break_exit", 32'h0, {31'h0, brk_st});
    // Break in wait with emulation on
    pulse(6'h28);
    @(posedge mclk_in);
    brk <= 1'b1;
    emul <= 1'b1;
    @(posedge mclk_in);
    brk <= 1'b0;
    emul <= 1'b0;
    #1;
    chk("brk_wait_vec", 32'h1, {27'h0, vec});
    apb(1'b0, eaw_pkg::OFS_BRK_STATUS, 32'h0);
    chk("brk_wake_flag", 32'h2, rd);
    apb(1'b1, eaw_pkg::OFS_BRK_STATUS, 32'h0);
    apb(1'b0, eaw_pkg::OFS_BRK_STATUS, 32'h0);
    chk("brk_wake_clear", 32'h0, rd);
    pulse(6'h02);
    $display("test_break done");
  endtask

  // Reset in mid-run returns the reset code
  task automatic test_reset();
    @(posedge mclk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    chk("reset_vec", 32'h0, {27'h0, vec});
    chk("reset_core_clk", 32'h1, {31'h0, core_clk});
    @(posedge mclk_in);
    reset_in <= 1'b0;
    $display("test_reset done");
  endtask

  // Main sequence
  initial begin
    errors = 0; tests_run = 0; cycles = 0;
    reset_in = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; irq_req = 16'h0; irq_en = 16'hFFFF; evt_drv = 6'h00;
    brk = 1'b0; slow = 1'b0; emul = 1'b0; wdog_dis = 1'b0;
    repeat (4) @(posedge mclk_in);
    reset_in <= 1'b0;
    test_regs();
    test_mask_trap();
    test_priority();
    test_wait();
    test_break();
    test_reset();
    stop_test();
  end
endmodule
